// *** src/lcs_params.svh ***
// What this block does
// R01: sixteen lines, three RAMs, codes 00-01-10
// R02: check address parity, refuse bad reads
// R03: card type readable by the scanner
// R04: config RAM parity error raises level-2 check
// R05: count word parity generated and checked
// R06: three RAMs gated independently on write
// R07: each entry unique, every bit settable
// R08: reset-latches clears every config entry
// R09: capture failing line in error address
// R10: increment count word in both RAMs
// R11: sync mode corrects +6/+4/-2/-4/none
// R12: correction only when line-change latch set
// R13: two count RAMs increment independently
// R14: start/stop mode forces count to 33
// R15: config entry selects internal bit rate
// R16: correction ranges fixed, decoded combinationally
// R17: odd parity per byte on buses
//
// Purpose: constants of the line bit clock control store
// Assumes: 50 MHz reference clock, AXI4-Lite register access
// Notes: definitions only
`ifndef LCS_PARAMS_SVH
`define LCS_PARAMS_SVH

// line count and entry width
`define LCS_LINES 16
`define LCS_LINE_W 4
`define LCS_ENTRY_W 9
`define LCS_PAR_BIT 8

// address map: byte address = {space, line, 2'b00}
`define LCS_ADDR_PAR_BIT 8
`define LCS_SPACE_CFG 2'h0
`define LCS_SPACE_CWA 2'h1
`define LCS_SPACE_CWB 2'h2
`define LCS_SPACE_CTL 2'h3
`define LCS_CTL_TYPE 4'h0
`define LCS_CTL_ERR 4'h1
`define LCS_CTL_CMD 4'h2

// command register fields
`define LCS_CMD_RESET_LATCHES 0
`define LCS_CMD_INCREMENT 1
`define LCS_CMD_LINE_LSB 8

// error register fields
`define LCS_ERR_CFG_BIT 8
`define LCS_ERR_CW_BIT 9

// config entry fields
`define LCS_CFG_SYNC_BIT 7
`define LCS_CFG_CLKEN_BIT 6
`define LCS_CFG_RATE_MSB 3
`define LCS_CFG_RATE_50BPS 4'h8

// cleared entry: zero data with its odd parity bit
`define LCS_ENTRY_CLEAR 9'h100

// count word correction values and range limits
`define LCS_CW_ASYNC_FORCE 8'h33
`define LCS_CW_LIM_P6 8'h10
`define LCS_CW_LIM_P4 8'h20
`define LCS_CW_LIM_NONE 8'h30
`define LCS_CW_LIM_M2 8'h38
`define LCS_CW_ADD_P6 8'h06
`define LCS_CW_ADD_P4 8'h04
`define LCS_CW_ADD_M2 8'hFE
`define LCS_CW_ADD_M4 8'hFC

// bit clock base rate
`define LCS_CLK_HZ 50000000
`define LCS_BASE_HZ 25600
`define LCS_BASE_DIV (`LCS_CLK_HZ / `LCS_BASE_HZ)

`endif

// *** src/lcs_pkg.sv ***
// Purpose: shared types of the line bit clock control store
// Assumes: constants come from lcs_params.svh
// Notes: types only
package lcs_pkg;

	// correction chosen for a line state change
	typedef enum logic [2:0]
	{
		LCS_CORR_P6,
		LCS_CORR_P4,
		LCS_CORR_NONE,
		LCS_CORR_M2,
		LCS_CORR_M4
	} lcs_corr_type;

	// count word RAM entry with parity
	typedef logic [8:0] lcs_entry_type;

endpackage : lcs_pkg

// *** src/lcs_cw_update.sv ***
// Purpose: next value of one count word on increment or line change
// Assumes: caller applies it only when an update is due
// Notes: purely combinational, parity generated on the result
`timescale 1ns/1ps
`include "lcs_params.svh"

module lcs_cw_update
	import lcs_pkg::*;
(
	// current word and line mode
	input wire logic [7:0] i_cw,
	input wire logic i_sync,
	// update causes
	input wire logic i_change,
	input wire logic i_inc,
	// result with odd parity
	output lcs_entry_type o_entry
);

	lcs_corr_type corr; // selected correction
	logic [7:0] nxt_cw; // updated word

	// range decode of the current word
	always_comb
	begin
		if (i_cw < `LCS_CW_LIM_P6) // [R16]
			corr = LCS_CORR_P6;
		else if (i_cw < `LCS_CW_LIM_P4)
			corr = LCS_CORR_P4;
		else if (i_cw < `LCS_CW_LIM_NONE)
			corr = LCS_CORR_NONE;
		else if (i_cw < `LCS_CW_LIM_M2)
			corr = LCS_CORR_M2;
		else
			corr = LCS_CORR_M4;
	end

	// change outranks increment
	always_comb
	begin
		nxt_cw = i_cw;
		if (i_change && !i_sync)
			nxt_cw = `LCS_CW_ASYNC_FORCE; // [R14]
		else if (i_change) // [R12]
		begin
			case (corr) // [R11]
				LCS_CORR_P6: nxt_cw = i_cw + `LCS_CW_ADD_P6;
				LCS_CORR_P4: nxt_cw = i_cw + `LCS_CW_ADD_P4;
				LCS_CORR_M2: nxt_cw = i_cw + `LCS_CW_ADD_M2;
				LCS_CORR_M4: nxt_cw = i_cw + `LCS_CW_ADD_M4;
				default: nxt_cw = i_cw;
			endcase
		end
		else if (i_inc)
			nxt_cw = i_cw + 8'h01; // [R10]
	end

	// odd parity generation
	assign o_entry = {~^nxt_cw, nxt_cw}; // [R05] [R17]

endmodule : lcs_cw_update

// *** src/lcs_top.sv ***
// Purpose: per-line bit clock control store behind an AXI4-Lite slave
// Assumes: one 50 MHz clock, line change pins asynchronous
// Notes: parity checked by a scan over all lines, one line per cycle
`timescale 1ns/1ps
`include "lcs_params.svh"

module lcs_top
	import lcs_pkg::*;
#(
	parameter logic [7:0] CARD_TYPE = 8'h5A // arbitrary card type value
)
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// axi write address
	input wire logic [31:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	// axi write data
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	// axi write response
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	// axi read address
	input wire logic [31:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	// axi read data
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	// line state change pins
	input wire logic [`LCS_LINES-1:0] i_line_change,
	// check condition
	output logic o_level2_check,
	output logic [`LCS_LINE_W-1:0] o_err_line
);

	localparam logic [1:0] RESP_OK = 2'h0; // okay answer
	localparam logic [1:0] RESP_ERR = 2'h2; // slave error answer
	localparam int BASE_DIV = `LCS_BASE_DIV; // cycles per base tick

	// storage in flip-flops, updater results combinational
	lcs_entry_type cfg_ff [`LCS_LINES]; // line config ram
	lcs_entry_type cw_ff [2][`LCS_LINES]; // count word rams a and b
	lcs_entry_type cw_nxt [2]; // updater results

	// bus state
	logic bvalid_ff; // write answer pending
	logic [1:0] bresp_ff; // write answer code
	logic rvalid_ff; // read answer pending
	logic [1:0] rresp_ff; // read answer code
	logic [31:0] rdata_ff; // read data

	// events and status
	logic [`LCS_LINES-1:0] chg_s1_ff; // change pin first stage
	logic [`LCS_LINES-1:0] chg_s2_ff; // change pin second stage
	logic [`LCS_LINES-1:0] chg_s3_ff; // edge reference
	logic [`LCS_LINES-1:0] chg_latch_ff; // line-change latches
	logic [`LCS_LINES-1:0] inc_pend_ff; // pending increments
	logic [`LCS_LINE_W-1:0] scan_ff; // line under scan
	logic err_cfg_ff; // config parity check
	logic err_cw_ff; // count word parity check
	logic [`LCS_LINE_W-1:0] err_line_ff; // failing line
	logic [11:0] base_cnt_ff; // base rate divider
	logic base_tick; // base rate enable
	logic [15:0] presc_ff; // rate prescaler

	// write decode
	logic wr_fire; // write taken this cycle
	logic wr_par_ok; // write address parity
	logic [1:0] wr_space; // selected ram or control
	logic [`LCS_LINE_W-1:0] wr_line; // selected entry
	logic wr_ok; // write lands
	logic wr_cmd; // command register write
	logic wr_err; // error register write
	logic rd_fire; // read taken this cycle
	logic rd_par_ok; // read address parity
	logic [1:0] rd_space; // read space
	logic [`LCS_LINE_W-1:0] rd_line; // read entry
	logic upd_go; // scan line update
	logic cfg_bad; // scan line config parity bad
	logic cw_bad; // scan line count parity bad
	logic clr_cfg; // error clear by software
	logic clr_cw; // error clear by software
	logic [`LCS_LINES-1:0] rate_tick; // per line bit clock

	// handshake: address and data taken together
	assign wr_fire = i_s_axi_awvalid && i_s_axi_wvalid && !bvalid_ff;
	assign o_s_axi_awready = i_s_axi_wvalid && !bvalid_ff;
	assign o_s_axi_wready = i_s_axi_awvalid && !bvalid_ff;
	assign o_s_axi_bvalid = bvalid_ff;
	assign o_s_axi_bresp = bresp_ff;
	assign rd_fire = i_s_axi_arvalid && !rvalid_ff;
	assign o_s_axi_arready = !rvalid_ff;
	assign o_s_axi_rvalid = rvalid_ff;
	assign o_s_axi_rresp = rresp_ff;
	assign o_s_axi_rdata = rdata_ff;

	// address fields and odd parity over the low address byte
	assign wr_par_ok = ^i_s_axi_awaddr[`LCS_ADDR_PAR_BIT:0]; // [R02] [R17]
	assign rd_par_ok = ^i_s_axi_araddr[`LCS_ADDR_PAR_BIT:0]; // [R02] [R17]
	assign wr_space = i_s_axi_awaddr[7:6]; // [R01]
	assign wr_line = i_s_axi_awaddr[5:2]; // [R07]
	assign rd_space = i_s_axi_araddr[7:6];
	assign rd_line = i_s_axi_araddr[5:2];
	assign wr_ok = wr_fire && wr_par_ok && i_s_axi_wstrb[0] && i_s_axi_wstrb[1];
	assign wr_cmd = wr_ok && wr_space == `LCS_SPACE_CTL && wr_line == `LCS_CTL_CMD;
	assign wr_err = wr_ok && wr_space == `LCS_SPACE_CTL && wr_line == `LCS_CTL_ERR;
	assign clr_cfg = wr_err && i_s_axi_wdata[`LCS_ERR_CFG_BIT];
	assign clr_cw = wr_err && i_s_axi_wdata[`LCS_ERR_CW_BIT];

	// write response, error on bad parity or unmapped address
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OK;
		end
		else if (wr_fire)
		begin
			bvalid_ff <= 1'b1;
			if (!wr_par_ok || (wr_space == `LCS_SPACE_CTL && wr_line > `LCS_CTL_CMD))
				bresp_ff <= RESP_ERR; // [R02]
			else
				bresp_ff <= RESP_OK;
		end
		else if (i_s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	// read answer, bad parity refused with error
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OK;
			rdata_ff <= 32'h0000_0000;
		end
		else if (rd_fire)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff <= RESP_OK;
			rdata_ff <= 32'h0000_0000;
			if (!rd_par_ok)
				rresp_ff <= RESP_ERR; // [R02]
			else
			begin
				case (rd_space) // [R01]
					`LCS_SPACE_CFG: rdata_ff <= {23'h0, cfg_ff[rd_line]};
					`LCS_SPACE_CWA: rdata_ff <= {23'h0, cw_ff[0][rd_line]};
					`LCS_SPACE_CWB: rdata_ff <= {23'h0, cw_ff[1][rd_line]};
					default:
					begin
						if (rd_line == `LCS_CTL_TYPE)
							rdata_ff <= {23'h0, ~^CARD_TYPE, CARD_TYPE}; // [R03]
						else if (rd_line == `LCS_CTL_ERR)
							rdata_ff <= {22'h0, err_cw_ff, err_cfg_ff, 4'h0, err_line_ff}; // [R09]
						else if (rd_line != `LCS_CTL_CMD)
							rresp_ff <= RESP_ERR; // unmapped
					end
				endcase
			end
		end
		else if (i_s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// config ram: bus write or reset-latches clear
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < `LCS_LINES; i++)
				cfg_ff[i] <= `LCS_ENTRY_CLEAR;
		end
		else if (wr_cmd && i_s_axi_wdata[`LCS_CMD_RESET_LATCHES])
		begin
			for (int i = 0; i < `LCS_LINES; i++)
				cfg_ff[i] <= `LCS_ENTRY_CLEAR; // [R08]
		end
		else if (wr_ok && wr_space == `LCS_SPACE_CFG)
			cfg_ff[wr_line] <= i_s_axi_wdata[8:0]; // [R06] [R07]
	end

	// two count word rams, each with its own updater
	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_cw
			lcs_cw_update u_upd
			(
				.i_cw(cw_ff[g][scan_ff][7:0]),
				.i_sync(cfg_ff[scan_ff][`LCS_CFG_SYNC_BIT]),
				.i_change(chg_latch_ff[scan_ff]),
				.i_inc(inc_pend_ff[scan_ff]),
				.o_entry(cw_nxt[g])
			);

			// bus write to this ram only, else scan update
			always_ff @(posedge i_ref_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					for (int i = 0; i < `LCS_LINES; i++)
						cw_ff[g][i] <= `LCS_ENTRY_CLEAR;
				end
				else if (wr_ok && wr_space == 2'(g + 1))
					cw_ff[g][wr_line] <= i_s_axi_wdata[8:0]; // [R06]
				else if (upd_go)
					cw_ff[g][scan_ff] <= cw_nxt[g]; // [R10] [R13]
			end
		end
	endgenerate

	// base rate divider, one pulse per base period
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			base_cnt_ff <= 12'h000;
		else if (base_tick)
			base_cnt_ff <= 12'h000;
		else
			base_cnt_ff <= base_cnt_ff + 12'h001;
	end
	assign base_tick = base_cnt_ff == 12'(BASE_DIV - 1);

	// prescaler for the per line rates
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			presc_ff <= 16'h0000;
		else if (base_tick)
			presc_ff <= presc_ff + 16'h0001;
	end

	// per line bit clock: base divided by 2^(rate+1)
	generate
		for (genvar l = 0; l < `LCS_LINES; l++)
		begin : g_rate
			logic [16:0] mask; // low prescaler bits for this rate
			assign mask = (17'h00002 << cfg_ff[l][`LCS_CFG_RATE_MSB:0]) - 17'h00001;
			assign rate_tick[l] = base_tick && cfg_ff[l][`LCS_CFG_CLKEN_BIT]
				&& (presc_ff & mask[15:0]) == mask[15:0]; // [R15]
		end
	endgenerate

	// change pin synchroniser and edge reference
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			chg_s1_ff <= 16'h0000;
			chg_s2_ff <= 16'h0000;
			chg_s3_ff <= 16'h0000;
		end
		else
		begin
			chg_s1_ff <= i_line_change;
			chg_s2_ff <= chg_s1_ff;
			chg_s3_ff <= chg_s2_ff;
		end
	end

	// scan pointer walks all lines
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			scan_ff <= 4'h0;
		else
			scan_ff <= scan_ff + 4'h1;
	end

	// update when something pends and no bus write lands this cycle
	assign upd_go = (chg_latch_ff[scan_ff] || inc_pend_ff[scan_ff]) && !wr_ok; // [R12]

	// line-change latches and pending increments, set wins over consume
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			chg_latch_ff <= 16'h0000;
			inc_pend_ff <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < `LCS_LINES; i++)
			begin
				if (chg_s2_ff[i] != chg_s3_ff[i])
					chg_latch_ff[i] <= 1'b1; // [R12]
				else if (upd_go && scan_ff == 4'(i))
					chg_latch_ff[i] <= 1'b0;
				if (rate_tick[i] || (wr_cmd && i_s_axi_wdata[`LCS_CMD_INCREMENT]
					&& i_s_axi_wdata[`LCS_CMD_LINE_LSB +: 4] == 4'(i)))
					inc_pend_ff[i] <= 1'b1; // [R10]
				else if (upd_go && scan_ff == 4'(i))
					inc_pend_ff[i] <= 1'b0;
			end
		end
	end

	// parity check of the scan line, odd parity expected
	assign cfg_bad = ~^cfg_ff[scan_ff]; // [R04] [R17]
	assign cw_bad = ~^cw_ff[0][scan_ff] || ~^cw_ff[1][scan_ff]; // [R05]

	// sticky check flags, set wins over software clear
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			err_cfg_ff <= 1'b0;
			err_cw_ff <= 1'b0;
			err_line_ff <= 4'h0;
		end
		else
		begin
			if (cfg_bad)
				err_cfg_ff <= 1'b1; // [R04]
			else if (clr_cfg)
				err_cfg_ff <= 1'b0;
			if (cw_bad)
				err_cw_ff <= 1'b1; // [R05]
			else if (clr_cw)
				err_cw_ff <= 1'b0;
			if (cfg_bad || cw_bad)
				err_line_ff <= scan_ff; // [R09]
		end
	end

	// level 2 check condition towards the scanner
	assign o_level2_check = err_cfg_ff || err_cw_ff; // [R04] [R05]
	assign o_err_line = err_line_ff;

endmodule : lcs_top

// *** verification/lcs_scanner_model.sv ***
// Purpose: scanner-side bus master that drives the control store registers
// Assumes: one clock, and each request starts just after a rising edge
// Notes: ports carry the names of the store's pins; a spent wait sets hung
`timescale 1ns/1ps
module lcs_scanner_model
(
	// clock
	input wire logic i_ref_clk,
	// write channels, driven here
	output logic [31:0] i_s_axi_awaddr,
	output logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	output logic [31:0] i_s_axi_wdata,
	output logic [3:0] i_s_axi_wstrb,
	output logic i_s_axi_wvalid,
	input wire logic o_s_axi_wready,
	input wire logic [1:0] o_s_axi_bresp,
	input wire logic o_s_axi_bvalid,
	output logic i_s_axi_bready,
	// read channels, driven here
	output logic [31:0] i_s_axi_araddr,
	output logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0] o_s_axi_rresp,
	input wire logic o_s_axi_rvalid,
	output logic i_s_axi_rready
);
	bit hung; // a bounded wait ran out
	// idle bus, answers always accepted
	initial
	begin
		i_s_axi_awaddr = 32'h0;
		i_s_axi_awvalid = 1'b0;
		i_s_axi_wdata = 32'h0;
		i_s_axi_wstrb = 4'hF;
		i_s_axi_wvalid = 1'b0;
		i_s_axi_bready = 1'b1;
		i_s_axi_araddr = 32'h0;
		i_s_axi_arvalid = 1'b0;
		i_s_axi_rready = 1'b1;
	end
	// one write, address and data offered together, odd address parity unless bad
	task automatic wr(input logic [7:0] a, input bit bad, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		i_s_axi_awaddr <= {23'h0, ~^a ^ bad, a};
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (!(o_s_axi_awready && o_s_axi_wready) && n < 200);
		i_s_axi_awvalid <= 1'b0;
		i_s_axi_wvalid <= 1'b0;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (!o_s_axi_bvalid && n < 400);
		r = o_s_axi_bresp;
		hung |= !o_s_axi_bvalid;
	endtask : wr
	// one read, same address parity scheme
	task automatic rd(input logic [7:0] a, input bit bad, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		i_s_axi_araddr <= {23'h0, ~^a ^ bad, a};
		i_s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (!o_s_axi_arready && n < 200);
		i_s_axi_arvalid <= 1'b0;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (!o_s_axi_rvalid && n < 400);
		d = o_s_axi_rdata;
		r = o_s_axi_rresp;
		hung |= !o_s_axi_rvalid;
	endtask : rd
endmodule : lcs_scanner_model

// *** verification/lcs_top_assertions.sv ***
// Purpose: bus answer and check condition properties of the control store
// Assumes: bound to lcs_top, one clock domain
// Notes: address parity is odd over bits [8:0]
`timescale 1ns/1ps
module lcs_checker
#(
	parameter logic [7:0] CARD_TYPE = 8'h5A
)
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// write side
	input wire logic [31:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	input wire logic i_s_axi_wvalid,
	input wire logic [1:0] o_s_axi_bresp,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	// read side
	input wire logic [31:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0] o_s_axi_rresp,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	// check condition
	input wire logic o_level2_check,
	input wire logic [3:0] o_err_line
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// address parity good on each channel
	wire logic aw_ok = ^i_s_axi_awaddr[8:0];
	wire logic ar_ok = ^i_s_axi_araddr[8:0];
	// transfers taken at this edge
	sequence s_wr_take;
		i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
	endsequence
	sequence s_rd_take;
		i_s_axi_arvalid && o_s_axi_arready;
	endsequence
	property p_wr_bad;
		s_wr_take ##0 !aw_ok |=> o_s_axi_bvalid && o_s_axi_bresp == 2'h2;
	endproperty
	a_wr_bad: assert property (p_wr_bad) else $error("bad write parity not refused");
	property p_b_drop;
		o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("write answer outstayed handshake");
	property p_rd_answer;
		s_rd_take |=> o_s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_r_drop;
		o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid;
	endproperty
	a_r_drop: assert property (p_r_drop) else $error("read answer outstayed handshake");
	property p_rd_bad;
		s_rd_take ##0 !ar_ok |=> o_s_axi_rresp == 2'h2 && o_s_axi_rdata == 32'h0;
	endproperty
	a_rd_bad: assert property (p_rd_bad) else $error("bad read parity completed");
	property p_rd_good;
		s_rd_take ##0 (ar_ok && i_s_axi_araddr[7:6] != 2'h3) |=> o_s_axi_rresp == 2'h0 && o_s_axi_rdata[31:9] == 23'h0;
	endproperty
	a_rd_good: assert property (p_rd_good) else $error("good entry read refused");
	property p_type;
		s_rd_take ##0 (ar_ok && i_s_axi_araddr[7:0] == 8'hC0) |=> o_s_axi_rdata == {23'h0, ~^CARD_TYPE, CARD_TYPE};
	endproperty
	a_type: assert property (p_type) else $error("card type wrong");
	property p_err_line;
		$changed(o_err_line) |=> o_level2_check;
	endproperty
	a_err_line: assert property (p_err_line) else $error("error line moved without check");
endmodule : lcs_checker

bind lcs_top lcs_checker #(.CARD_TYPE(CARD_TYPE)) lcs_checker_inst (.*);

// *** verification/lcs_top_tb.sv ***
// Purpose: self-checking bench of the line bit clock control store
// Assumes: 50 MHz clock, fixed seed, scanner model on the register bus
// Notes: count-word updates get 40 cycles to land
`timescale 1ns/1ps
`include "lcs_params.svh"
module lcs_top_tb;
	localparam logic [7:0] CT = 8'h3C; // arbitrary card type
	// design pins
	logic i_ref_clk, i_rst_n, i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready;
	logic o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid, i_s_axi_rready;
	logic [31:0] i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_araddr, o_s_axi_rdata;
	logic [3:0] i_s_axi_wstrb, o_err_line;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
	logic [15:0] i_line_change;
	logic o_level2_check;
	// bench state
	int n_fail, total_checks, seed, p, s, l, n;
	logic [7:0] exp_mem [3][16];
	logic [7:0] v;
	logic [31:0] d;
	logic [3:0] ln;
	logic [7:0] corner [8] = '{8'h0F, 8'h10, 8'h1F, 8'h2F, 8'h30, 8'h37, 8'h38, 8'hFF};
	lcs_top #(.CARD_TYPE(CT)) lcs_top_inst (.*);
	lcs_scanner_model lcs_scanner_model_inst (.*);
	// free-running clock
	initial
	begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	// word as stored: data with odd parity in bit 8
	function automatic logic [31:0] ent(input logic [7:0] x);
		return {23'h0, ~^x, x};
	endfunction : ent
	// synchronous-mode correction by range of the count word
	function automatic logic [7:0] corr(input logic [7:0] x);
		if (x < `LCS_CW_LIM_P6) return x + 8'h06;
		if (x < `LCS_CW_LIM_P4) return x + 8'h04;
		if (x < `LCS_CW_LIM_NONE) return x;
		if (x < `LCS_CW_LIM_M2) return x - 8'h02;
		return x - 8'h04;
	endfunction : corr
	// fill pattern of pass q for line y
	function automatic logic [7:0] pat(input int q, input logic [3:0] y);
		case (q)
			0: return {4'h0, y};
			1: return {4'hF, ~y};
			2: return 8'hAA;
			3: return 8'h55;
			default: return 8'($random(seed));
		endcase
	endfunction : pat
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (lcs_scanner_model_inst.hung) n_fail++;
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	// bus wrappers: bad flips the address parity and expects a refusal
	task automatic wr(input logic [7:0] a, input logic [31:0] x, input bit bad);
		logic [1:0] e;
		lcs_scanner_model_inst.wr(a, bad, x, e);
		if (lcs_scanner_model_inst.hung) tally_and_finish;
		chk("bresp", {30'h0, bad, 1'b0}, {30'h0, e});
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] x, input bit bad);
		logic [1:0] e;
		lcs_scanner_model_inst.rd(a, bad, x, e);
		if (lcs_scanner_model_inst.hung) tally_and_finish;
		chk("rresp", {30'h0, bad, 1'b0}, {30'h0, e});
	endtask : rd
	task automatic settle;
		repeat (40) @(posedge i_ref_clk);
	endtask : settle
	initial
	begin
		seed = 23596;
		i_rst_n = 1'b0;
		i_line_change = 16'h0;
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		@(posedge i_ref_clk);
		rd(8'hC0, d, 0);
		chk("type", ent(CT), d);
		// every entry of all three spaces, order reversed on odd passes
		for (p = 0; p < 5; p++)
		begin
			for (s = 0; s < 3; s++)
				for (l = 0; l < 16; l++)
				begin
					ln = p[0] ? 4'(15 - l) : 4'(l);
					n = p[0] ? 2 - s : s;
					v = pat(p, ln);
					exp_mem[n][ln] = (n == 0 && p != 3) ? v & 8'hBF : v;
					wr({n[1:0], ln, 2'b00}, ent(exp_mem[n][ln]), 0);
				end
			for (s = 0; s < 3; s++)
				for (l = 0; l < 16; l++)
				begin
					rd({s[1:0], l[3:0], 2'b00}, d, 0);
					chk("entry", ent(exp_mem[s][l]), d);
					rd({s[1:0], l[3:0], 2'b00}, d, 1);
					chk("bad parity read", 32'h0, d);
				end
			wr(8'hC8, 32'h1, 0);
			settle;
			for (l = 0; l < 16; l++)
			begin
				rd({2'h0, l[3:0], 2'b00}, d, 0);
				chk("cleared", 32'h100, d);
			end
			chk("no check", 32'h0, {31'h0, o_level2_check});
		end
		// refused write leaves the entry alone
		wr(8'h40, ent(8'h22), 0);
		wr(8'h40, ent(8'h11), 1);
		rd(8'h40, d, 0);
		chk("refused write", ent(8'h22), d);
		// bad data parity in config then count word
		for (s = 0; s < 2; s++)
		begin
			ln = 4'($random(seed));
			wr({s[1:0], ln, 2'b00}, ent(8'hA0) ^ 32'h100, 0);
			for (n = 0; n < 40 && o_level2_check !== 1'b1; n++) @(posedge i_ref_clk);
			chk("check raised", 32'h1, {31'h0, o_level2_check});
			rd(8'hC4, d, 0);
			chk("error line", {28'h0, ln}, {28'h0, d[3:0]});
			chk("error line pin", {28'h0, ln}, {28'h0, o_err_line});
			chk("error kind", s + 1, {30'h0, d[9:8]});
			wr({s[1:0], ln, 2'b00}, ent(8'h00), 0);
			settle;
			wr(8'hC4, 32'h300, 0);
			settle;
			chk("check cleared", 32'h0, {31'h0, o_level2_check});
		end
		// increment both count words of a random line
		for (n = 0; n < 4; n++)
		begin
			ln = 4'($random(seed));
			v = 8'($random(seed));
			wr({2'h1, ln, 2'b00}, ent(v), 0);
			wr({2'h2, ln, 2'b00}, ent(~v), 0);
			wr(8'hC8, {20'h0, ln, 8'h02}, 0);
			settle;
			rd({2'h1, ln, 2'b00}, d, 0);
			chk("inc a", ent(v + 8'h01), d);
			rd({2'h2, ln, 2'b00}, d, 0);
			chk("inc b", ent(~v + 8'h01), d);
		end
		// line change: start/stop on range corners, then sync on corners and random words
		for (p = 0; p < 20; p++)
		begin
			ln = 4'($random(seed));
			v = (p < 16) ? corner[p % 8] : 8'($random(seed));
			wr({2'h0, ln, 2'b00}, ent(p < 8 ? 8'h00 : 8'h80), 0);
			wr({2'h1, ln, 2'b00}, ent(v), 0);
			wr({2'h2, ln, 2'b00}, ent(v), 0);
			i_line_change[ln] <= ~i_line_change[ln];
			settle;
			rd({2'h1, ln, 2'b00}, d, 0);
			chk("change a", ent(p < 8 ? 8'h33 : corr(v)), d);
			rd({2'h2, ln, 2'b00}, d, 0);
			chk("change b", ent(p < 8 ? 8'h33 : corr(v)), d);
		end
		// internal bit clock at rate 0, enabled for exactly two base periods: one increment
		ln = 4'($random(seed));
		wr({2'h1, ln, 2'b00}, ent(8'h10), 0);
		wr({2'h0, ln, 2'b00}, ent(8'h40), 0);
		repeat (2 * `LCS_BASE_DIV - 2) @(posedge i_ref_clk);
		wr({2'h0, ln, 2'b00}, ent(8'h00), 0);
		settle;
		rd({2'h1, ln, 2'b00}, d, 0);
		chk("rate tick", ent(8'h11), d);
		tally_and_finish;
	end
endmodule : lcs_top_tb
